//--- design/sdram_cmd_map.vh
`ifndef SDRAM_CMD_MAP_VH
`define SDRAM_CMD_MAP_VH

// ----------------------------------------------------------------------------
// register map (Avalon word addresses, byte address = index * 4)
// ----------------------------------------------------------------------------
`define REG_CONTROL      2'h0
`define REG_COMMAND      2'h1
`define REG_STATUS       2'h2
`define REG_RDATA        2'h3

// control register fields
`define CTL_RDLAT_LO     0
`define CTL_RDLAT_HI     1
`define CTL_WRLAT_LO     2
`define CTL_WRLAT_HI     3
`define CTL_CLKEN        4
`define CTL_RESET        32'h0000_0010

// command register fields
`define CMD_OP_LO        0
`define CMD_OP_HI        2
`define CMD_XOPT         3
`define CMD_ADDR_LO      4
`define CMD_ADDR_HI      15
`define CMD_BANK_LO      16
`define CMD_BANK_HI      17
`define CMD_WDATA_LO     16
`define CMD_WDATA_HI     31

// command opcodes
`define OP_NOP           3'h0
`define OP_READ          3'h1
`define OP_WRITE         3'h2
`define OP_ROW_ACTIVATE_CMD          3'h3
`define OP_CLOSE_ALL     3'h4
`define OP_CLOSE_ONE     3'h5
`define OP_REFRESH       3'h6

// sdram pin codes {row, col, we}
`define PIN_NOP          3'h7
`define PIN_ROW_ACTIVATE_CMD         3'h3
`define PIN_READ         3'h5
`define PIN_WRITE        3'h4
`define PIN_PRECH        3'h2
`define PIN_BANK_REFRESH_CMD         3'h1

// timing
`define CAS_LATENCY      3'h3
`define ADDR_AP_BIT      10
`define BUSY_BIT         0
`define ZERO32           32'h0000_0000
`define LAT_MAX          3'h3

`endif

//--- design/sync_edge.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// two-stage synchroniser with rising edge detect
// ----------------------------------------------------------------------------
module sync_edge
(
  input  wire ref_clk,
  input  wire srst,
  input  wire asyncIn,
  output reg  riseEdge
);
  reg       meta_q;
  reg       sync_q;
  reg       last_q;
  // marks when last_q holds a real pin sample, so that a pin already high
  // when reset ends is not taken for a rising edge
  reg [2:0] fill_q;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_q   <= 1'b0;
      sync_q   <= 1'b0;
      last_q   <= 1'b0;
      fill_q   <= 3'h0;
      riseEdge <= 1'b0;
    end
    else
    begin
      meta_q   <= asyncIn;
      sync_q   <= meta_q;
      last_q   <= sync_q;
      fill_q   <= {fill_q[1:0], 1'b1};
      riseEdge <= sync_q & ~last_q & fill_q[2];
    end
  end
endmodule // sync_edge

//--- design/strobe_delay.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// delays a strobe by 0..3 memory clocks, shifting on each memory clock edge
// ----------------------------------------------------------------------------
module strobe_delay
(
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       memEdge,
  input  wire [1:0] latency,
  input  wire       strobeIn,
  output wire       strobeOut
);
  reg [2:0] tap_q;

  always @(posedge ref_clk)
  begin
    if (srst)
      tap_q <= 3'h0;
    else if (memEdge)
      tap_q <= {tap_q[1:0], strobeIn};
  end

  assign strobeOut = (latency == 2'h0) ? strobeIn : tap_q[latency - 2'h1];
endmodule // strobe_delay

//--- design/sdram_cmd_peripheral_transfer.v
`timescale 1ns/1ns
`include "sdram_cmd_map.vh"

// Overview of operation
// RQ1 - During SDRAM accesses the three shared strobes carry column strobe, write enable and row strobe in that pairing.
// RQ2 - The transfer strobe is raised on a read only when the source-side direct option is set.
// RQ3 - The transfer strobe is raised on a write only when the destination-side direct option is set.
// RQ4 - A direct read does not capture the returned SDRAM data.
// RQ5 - A direct write leaves the data bus undriven so the peripheral supplies the data.
// RQ6 - The read latency field delays the transfer strobe 0 to 3 memory clocks after the read data phase.
// RQ7 - The write latency field delays the transfer strobe 0 to 3 memory clocks after the write data phase.
// RQ8 - Reads use a CAS latency of three memory clocks and the SDRAM returns data then.
// RQ9 - A refresh command is issued distinct from all other commands.
// RQ10 - Activate, close-all-banks and close-one-bank commands are all provided.
// RQ11 - The clock-enable output exists only on the wide port instance; the narrow instance keeps the port and holds it low.
// RQ12 - All memory outputs change only on rising edges of the memory clock.
module sdram_cmd_peripheral_transfer
#(
  parameter WIDE_PORT = 1
)
(
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        mem_clk_out,
  output reg         chip_select_n,
  output reg         shared_strobe_a,
  output reg         shared_strobe_b,
  output reg         shared_strobe_c,
  output reg  [1:0]  byte_lane_en,
  output reg  [11:0] mem_addr_bus,
  output reg  [1:0]  mem_bank_sel,
  input  wire [15:0] mem_data_in,
  output reg  [15:0] mem_data_out,
  output reg         mem_data_oe_n,
  output reg         sdram_clk_en,
  output reg         direct_xfer_strobe
);
  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam ST_IDLE  = 4'b0001;
  localparam ST_ISSUE = 4'b0010;
  localparam ST_WAIT  = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg  [3:0]  state_q;
  reg  [31:0] control_q;
  reg  [31:0] cmd_q;
  reg  [15:0] rdata_q;
  reg  [2:0]  wait_q;
  reg  [15:0] dataMeta_q;
  reg  [15:0] dataSync_q;
  reg         ack_q;
  wire        busTake;
  wire        busDone;
  wire        cmdWrite;
  wire        ctlWrite;
  wire        isRead;
  wire        isWrite;
  wire        isCloseAll;
  wire        isCloseOne;
  wire        rdPhase;
  wire        wrPhase;
  wire        memEdge;
  wire        rdStrobe;
  wire        wrStrobe;
  wire [2:0]  op;
  wire        xopt;

  assign op   = cmd_q[`CMD_OP_HI:`CMD_OP_LO];
  assign xopt = cmd_q[`CMD_XOPT];
  assign isRead     = (op == `OP_READ);
  assign isWrite    = (op == `OP_WRITE);
  assign isCloseAll = (op == `OP_CLOSE_ALL);
  assign isCloseOne = (op == `OP_CLOSE_ONE);

  function [2:0] pin_code;
    input [2:0] opc;
    begin
      case (opc)
        `OP_READ:      pin_code = `PIN_READ;
        `OP_WRITE:     pin_code = `PIN_WRITE;
        `OP_ROW_ACTIVATE_CMD:      pin_code = `PIN_ROW_ACTIVATE_CMD;     // RQ10
        `OP_CLOSE_ALL: pin_code = `PIN_PRECH;    // RQ10
        `OP_CLOSE_ONE: pin_code = `PIN_PRECH;    // RQ10
        `OP_REFRESH:   pin_code = `PIN_BANK_REFRESH_CMD;     // RQ9
        default:       pin_code = `PIN_NOP;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // register bus decode
  // --------------------------------------------------------------------------
  // a request is taken in its first cycle and completed in its second
  assign busTake  = (avs_read | avs_write) & ~ack_q;
  assign busDone  = (avs_read | avs_write) & ack_q;
  assign ctlWrite = avs_write & busDone & (avs_address == `REG_CONTROL);
  assign cmdWrite = avs_write & busDone & (avs_address == `REG_COMMAND);

  // --------------------------------------------------------------------------
  // data phase decode
  // --------------------------------------------------------------------------
  // decoded from the state that the current memory edge acts on, so that a
  // zero latency puts the transfer strobe on the very edge of the data phase
  assign rdPhase = (state_q == ST_WAIT) & (wait_q == 3'h0);
  assign wrPhase = (state_q == ST_ISSUE) & isWrite;

  // --------------------------------------------------------------------------
  // read data capture
  // --------------------------------------------------------------------------
  // two flops deep before the sequencer reads it; the memory edge itself lags
  // the pin by three flops, so the word sampled is still that of the edge
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      dataMeta_q <= 16'h0;
      dataSync_q <= 16'h0;
    end
    else
    begin
      dataMeta_q <= mem_data_in;
      dataSync_q <= dataMeta_q;
    end
  end

  // --------------------------------------------------------------------------
  // memory clock edges
  // --------------------------------------------------------------------------
  sync_edge u_edge
  (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .asyncIn  (mem_clk_out),
    .riseEdge (memEdge)
  );

  // --------------------------------------------------------------------------
  // transfer strobe latency
  // --------------------------------------------------------------------------
  strobe_delay u_rd_delay
  (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .memEdge   (memEdge),
    .latency   (control_q[`CTL_RDLAT_HI:`CTL_RDLAT_LO]),
    .strobeIn  (rdPhase & xopt),
    .strobeOut (rdStrobe)
  ); // RQ2 RQ6

  strobe_delay u_wr_delay
  (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .memEdge   (memEdge),
    .latency   (control_q[`CTL_WRLAT_HI:`CTL_WRLAT_LO]),
    .strobeIn  (wrPhase & xopt),
    .strobeOut (wrStrobe)
  ); // RQ3 RQ7

  // --------------------------------------------------------------------------
  // register bus: writes take effect when waitrequest is low
  // --------------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      control_q       <= `CTL_RESET;
      avs_readdata    <= `ZERO32;
      avs_waitrequest <= 1'b1;
      ack_q           <= 1'b0;
    end
    else
    begin
      // one wait cycle per access, then a single low waitrequest
      ack_q           <= busTake;
      avs_waitrequest <= ~busTake;
      // read data is loaded in the taking cycle and then held until the next access
      if (busTake)
      begin
        case (avs_address)
          `REG_CONTROL: avs_readdata <= control_q;
          `REG_COMMAND: avs_readdata <= cmd_q;
          `REG_STATUS:  avs_readdata <= {31'h0, (state_q != ST_IDLE)};
          `REG_RDATA:   avs_readdata <= {16'h0, rdata_q};
          default:      avs_readdata <= `ZERO32;
        endcase
      end
      if (ctlWrite)
        control_q <= avs_writedata;
    end
  end

  // --------------------------------------------------------------------------
  // command sequencer, steps on memory clock edges except idle to issue, which a command write makes at once
  // --------------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q            <= ST_IDLE;
      cmd_q              <= `ZERO32;
      rdata_q            <= 16'h0;
      wait_q             <= 3'h0;
      chip_select_n      <= 1'b1;
      shared_strobe_a    <= 1'b1;
      shared_strobe_b    <= 1'b1;
      shared_strobe_c    <= 1'b1;
      byte_lane_en       <= 2'h0;
      mem_addr_bus       <= 12'h0;
      mem_bank_sel       <= 2'h0;
      mem_data_out       <= 16'h0;
      mem_data_oe_n      <= 1'b1;
      sdram_clk_en       <= 1'b0;
      direct_xfer_strobe <= 1'b0;
    end
    else
    begin
      // commands issued while busy are dropped; software polls status
      if (cmdWrite & (state_q == ST_IDLE))
      begin
        cmd_q   <= avs_writedata;
        state_q <= ST_ISSUE;
      end
      else if (memEdge)
      begin
        sdram_clk_en       <= (WIDE_PORT != 0) & control_q[`CTL_CLKEN]; // RQ11
        direct_xfer_strobe <= rdStrobe | wrStrobe; // RQ12
        chip_select_n      <= 1'b1;
        {shared_strobe_c, shared_strobe_a, shared_strobe_b} <= `PIN_NOP;
        case (state_q)
          ST_IDLE:
            mem_data_oe_n <= 1'b1;
          ST_ISSUE:
          begin
            chip_select_n <= 1'b0;
            // row, column, write enable order of the pin code
            {shared_strobe_c, shared_strobe_a, shared_strobe_b} <= pin_code(op); // RQ1 RQ12
            mem_addr_bus  <= cmd_q[`CMD_ADDR_HI:`CMD_ADDR_LO];
            mem_bank_sel  <= cmd_q[`CMD_BANK_HI:`CMD_BANK_LO];
            // the precharge bit picks all banks or only the bank addressed
            if (isCloseAll)
              mem_addr_bus[`ADDR_AP_BIT] <= 1'b1;
            if (isCloseOne)
              mem_addr_bus[`ADDR_AP_BIT] <= 1'b0;
            byte_lane_en  <= (isRead | isWrite) ? 2'h3 : 2'h0;
            if (isWrite)
            begin
              mem_data_out  <= cmd_q[`CMD_WDATA_HI:`CMD_WDATA_LO];
              mem_data_oe_n <= xopt; // RQ5
              state_q       <= ST_DONE;
            end
            else if (isRead)
            begin
              wait_q  <= `CAS_LATENCY - 3'h1; // RQ8
              state_q <= ST_WAIT;
            end
            else
              state_q <= ST_DONE;
          end
          ST_WAIT:
          begin
            if (wait_q == 3'h0)
            begin
              // data phase of the read; a direct read leaves the word to the peripheral
              if (!xopt)
                rdata_q <= dataSync_q; // RQ4
              state_q <= ST_DONE;
            end
            else
              wait_q <= wait_q - 3'h1;
          end
          ST_DONE:
          begin
            // let the latency pipe drain before the next command
            mem_data_oe_n <= 1'b1;
            byte_lane_en  <= 2'h0;
            if (wait_q == `LAT_MAX)
            begin
              wait_q  <= 3'h0;
              state_q <= ST_IDLE;
            end
            else
              wait_q <= wait_q + 3'h1;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // sdram_cmd_peripheral_transfer

//--- dv/sdram_model.sv
`timescale 1ns/1ns
// ------
// sdram data side, cas latency three
// ------
module sdram_model
(
  input  wire        memClk,
  input  wire        csN,
  input  wire        rowN,
  input  wire        colN,
  input  wire        weN,
  input  wire [15:0] word,
  output reg  [15:0] dq = 16'h0
);
  reg [3:0] pipe = 4'h0;

  // word stands around the third edge; afterwards it is inverted, never held
  always @(posedge memClk)
  begin
    pipe <= {pipe[2:0], !csN && rowN && !colN && weN};
    if (pipe[1])
      dq <= word;
    else if (pipe[3])
      dq <= ~dq;
  end
endmodule // sdram_model

//--- dv/sdram_cmd_checker_props.sv
`timescale 1ns/1ns
// ------
// port checker
// ------
module sdram_cmd_checker
#(
  parameter WIDE_PORT = 1
)
(
  input wire        ref_clk,
  input wire        srst,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        mem_clk_out,
  input wire        chip_select_n,
  input wire        shared_strobe_a,
  input wire        shared_strobe_b,
  input wire        shared_strobe_c,
  input wire        mem_data_oe_n,
  input wire        sdram_clk_en,
  input wire        direct_xfer_strobe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  reg        clkQ;
  reg  [3:0] sinceRise;
  reg  [2:0] lastCode;
  wire [2:0] code = {shared_strobe_c, shared_strobe_a, shared_strobe_b};

  // age of the last memory clock rise; the synchroniser costs a few cycles
  always @(posedge ref_clk)
  begin
    clkQ <= mem_clk_out;
    if (srst)
      sinceRise <= 4'hF;
    else if (mem_clk_out && !clkQ)
      sinceRise <= 4'h0;
    else if (sinceRise != 4'hF)
      sinceRise <= sinceRise + 4'h1;
    if (srst)
      lastCode <= 3'h7;
    else if (!chip_select_n)
      lastCode <= code;
  end

  sequence strobeHeld;
    direct_xfer_strobe [*8] ##1 !direct_xfer_strobe;
  endsequence

  wait_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("late bus answer");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  read_hold_a: assert property (!$past(avs_read || avs_write) |-> $stable(avs_readdata))
    else $error("read data moved");
  cmd_code_a: assert property (!chip_select_n |-> code inside {3'h5, 3'h4, 3'h3, 3'h2, 3'h1})
    else $error("bad strobe code");
  pin_edge_a: assert property ($changed({chip_select_n, code, mem_data_oe_n, direct_xfer_strobe}) |-> sinceRise <= 4'h5)
    else $error("pin moved off memory edge");
  strobe_width_a: assert property ($rose(direct_xfer_strobe) |-> strobeHeld)
    else $error("strobe width");
  // a write with zero latency raises the strobe together with its command
  strobe_cmd_a: assert property ($rose(direct_xfer_strobe) |-> (chip_select_n ? lastCode : code) inside {3'h5, 3'h4})
    else $error("strobe without data command");
  data_drive_a: assert property (!mem_data_oe_n |-> !chip_select_n && code == 3'h4)
    else $error("data driven outside write");
  clk_en_a: assert property (sdram_clk_en |-> WIDE_PORT != 0)
    else $error("clock enable on narrow port");
endmodule // sdram_cmd_checker

bind sdram_cmd_peripheral_transfer sdram_cmd_checker #(.WIDE_PORT(WIDE_PORT)) sdram_cmd_checker_i
(
  .ref_clk, .srst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .mem_clk_out,
  .chip_select_n, .shared_strobe_a, .shared_strobe_b, .shared_strobe_c, .mem_data_oe_n,
  .sdram_clk_en, .direct_xfer_strobe
);

//--- dv/test_sdram_cmd_peripheral_transfer.sv
`timescale 1ns/1ns
`include "sdram_cmd_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("mismatch %0t got %h", $time, a); end end
// ------
// bench
// ------
module test_sdram_cmd_peripheral_transfer;
  logic        ref_clk = 0;
  logic        srst = 1;
  logic        memClk = 0;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] modelWord = 16'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, chip_select_n, shared_strobe_a, shared_strobe_b, shared_strobe_c;
  wire  [1:0]  byte_lane_en, mem_bank_sel;
  wire  [11:0] mem_addr_bus;
  wire  [15:0] mem_data_in, mem_data_out;
  wire         mem_data_oe_n, sdram_clk_en, direct_xfer_strobe, narrowClkEn;
  logic [31:0] rd;
  logic [3:0]  lat;
  logic [2:0]  code;
  logic [15:0] dOut, lastWord = 16'h0;
  logic        memQ, cmdSeen, strbSeen, a10, oeN;
  int          edges = 0, t0, tS, checked = 0, fails = 0;

  always #4 ref_clk = ~ref_clk;
  always #32 memClk = ~memClk;

  sdram_cmd_peripheral_transfer #(.WIDE_PORT(1)) sdram_cmd_peripheral_transfer_i
  (
    .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mem_clk_out(memClk), .chip_select_n, .shared_strobe_a, .shared_strobe_b,
    .shared_strobe_c, .byte_lane_en, .mem_addr_bus, .mem_bank_sel, .mem_data_in, .mem_data_out,
    .mem_data_oe_n, .sdram_clk_en, .direct_xfer_strobe
  );

  sdram_cmd_peripheral_transfer #(.WIDE_PORT(0)) sdram_cmd_peripheral_transfer_narrow_i
  (
    .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata(),
    .avs_waitrequest(), .mem_clk_out(memClk), .chip_select_n(), .shared_strobe_a(), .shared_strobe_b(),
    .shared_strobe_c(), .byte_lane_en(), .mem_addr_bus(), .mem_bank_sel(), .mem_data_in, .mem_data_out(),
    .mem_data_oe_n(), .sdram_clk_en(narrowClkEn), .direct_xfer_strobe()
  );

  sdram_model sdram_model_i
  (
    .memClk, .csN(chip_select_n), .rowN(shared_strobe_c), .colN(shared_strobe_a),
    .weN(shared_strobe_b), .word(modelWord), .dq(mem_data_in)
  );

  // first command cycle only, so later strobe edges are timed from it
  always @(posedge ref_clk)
  begin
    memQ <= memClk;
    if (memClk && !memQ)
      edges <= edges + 1;
    if (avs_write && avs_address == `REG_COMMAND)
    begin
      cmdSeen <= 0;
      strbSeen <= 0;
    end
    else if (!chip_select_n && !cmdSeen)
    begin
      cmdSeen <= 1;
      code <= {shared_strobe_c, shared_strobe_a, shared_strobe_b};
      a10 <= mem_addr_bus[10];
      oeN <= mem_data_oe_n;
      dOut <= mem_data_out;
      t0 <= edges;
    end
    if (direct_xfer_strobe && !strbSeen)
    begin
      strbSeen <= 1;
      tS <= edges;
    end
  end

  function automatic [2:0] pinCode(input [2:0] op);
    case (op)
      3'h1: pinCode = 3'h5;
      3'h2: pinCode = 3'h4;
      3'h3: pinCode = 3'h3;
      3'h4, 3'h5: pinCode = 3'h2;
      default: pinCode = 3'h1;
    endcase
  endfunction

  task automatic av(input bit w, input [1:0] a, input [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50)
      fails++;
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge ref_clk);
  endtask

  task automatic doOp(input [2:0] op, input bit x);
    int n;
    logic [15:0] wd;
    n = 0;
    wd = 16'($urandom);
    modelWord <= 16'($urandom);
    av(1, `REG_COMMAND, {wd, 12'($urandom), x, op});
    do
    begin
      av(0, `REG_STATUS, 32'h0);
      n++;
    end
    while ((rd[0] !== 1'b0 || cmdSeen !== 1'b1) && n < 60);
    if (n == 60)
      fails++;
    `CHK(code, pinCode(op))
    if (op == 3'h4 || op == 3'h5)
      `CHK(a10, op == 3'h4)
    if (op == `OP_READ)
    begin
      `CHK(strbSeen, x)
      if (x)
        `CHK(tS - t0, 3 + lat[1:0])
      av(0, `REG_RDATA, 32'h0);
      if (!x)
        lastWord = modelWord;
      `CHK(rd[15:0], lastWord)
    end
    else if (op == `OP_WRITE)
    begin
      `CHK(strbSeen, x)
      `CHK(oeN, x)
      if (x)
        `CHK(tS - t0, lat[3:2])
      else
        `CHK(dOut, wd)
    end
    else
      `CHK(strbSeen, 1'b0)
  endtask

  task finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    finish_test();
  end

  initial
  begin
    rd = $urandom(90);
    repeat (5) @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    av(0, `REG_CONTROL, 32'h0);
    `CHK(rd, `CTL_RESET)
    // first twelve walk every opcode but NOP plain and direct, the rest are random
    for (int i = 0; i < 30; i++)
    begin
      lat = 4'($urandom);
      av(1, `REG_CONTROL, {28'h1, lat});
      doOp(i < 12 ? 3'(i % 6 + 1) : 3'($urandom_range(6, 1)), i < 12 ? 1'(i / 6) : 1'($urandom));
    end
    `CHK(sdram_clk_en, 1'b1)
    `CHK(narrowClkEn, 1'b0)
    av(1, `REG_CONTROL, 32'h0);
    repeat (2) @(posedge memClk);
    @(posedge ref_clk);
    `CHK(sdram_clk_en, 1'b0)
    finish_test();
  end
endmodule // test_sdram_cmd_peripheral_transfer
